//--- design/sgdc_regs.svh
`ifndef SGDC_REGS_SVH
`define SGDC_REGS_SVH

// Mode word fields
`define SGDC_MR_BL_LSB 0
`define SGDC_MR_BL_MSB 2
`define SGDC_MR_BT_BIT 3
`define SGDC_MR_CL_LSB 4
`define SGDC_MR_CL_MSB 6
`define SGDC_MR_DUAL_BIT 7
`define SGDC_MR_SWR_BIT 8
`define SGDC_MR_RESET 10'h020

// Burst length codes
`define SGDC_BL_1 3'h0
`define SGDC_BL_2 3'h1
`define SGDC_BL_4 3'h2
`define SGDC_BL_8 3'h3
`define SGDC_BL_FULL 3'h7

// Read latency codes
`define SGDC_CL_2 3'h2
`define SGDC_CL_3 3'h3

// Special mode address fields
`define SGDC_SM_MASK_BIT 5
`define SGDC_SM_COLOUR_BIT 6
`define SGDC_SM_SEL_BIT 7

// Command address fields
`define SGDC_AUTO_BIT 8
`define SGDC_COL_MSB 7
`define SGDC_BLK_LSB 3
`define SGDC_DUAL_SEL_BIT 0

// Timing
`define SGDC_MODE_WAIT 2'h2
`define SGDC_CLK_PERIOD_NS 20
`define SGDC_REF_INTERVAL_NS 15600
`define SGDC_REF_CYCLES ((`SGDC_REF_INTERVAL_NS) / (`SGDC_CLK_PERIOD_NS))

`endif

//--- design/sgdc_pkg.sv
package sgdc_pkg;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_MODE, CMD_SMODE, CMD_OPEN, CMD_OPEN_M, CMD_READ, CMD_WRITE,
      CMD_BLOCK, CMD_STOP, CMD_CLOSE, CMD_REFRESH, CMD_SELF_REFRESH_CMD
   } sgdc_cmd_e;

   typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_SELF_REFRESH_CMD} sgdc_pwr_e;

   typedef enum logic [1:0] {BK_IDLE, BK_READ, BK_WRITE} sgdc_burst_e;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic special_function_pin;
      logic [3:0] dqm;
      logic ba;
      logic [9:0] addr;
   } sgdc_pins_s;

   typedef struct packed {
      logic valid;
      logic bank;
      logic [9:0] row;
      logic [7:0] col;
   } sgdc_rd_s;

   typedef struct packed {
      logic blk;
      logic bank;
      logic [9:0] row;
      logic [7:0] col;
      logic [31:0] data;
      logic [31:0] bit_en;
      logic [31:0] col_en;
   } sgdc_wr_s;

endpackage

//--- design/sgdc_wbuf.sv
`timescale 1ns/1ps
module sgdc_wbuf
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire sgdc_pkg::sgdc_wr_s in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output sgdc_pkg::sgdc_wr_s out_data_o
);

   typedef struct packed {
      logic v0;
      logic v1;
      sgdc_pkg::sgdc_wr_s d0;
      sgdc_pkg::sgdc_wr_s d1;
   } sgdc_wbuf_s;

   sgdc_wbuf_s s_q;
   sgdc_wbuf_s s_d;

   always_comb
   begin
      s_d = s_q;
      if (s_q.v0 && out_ready_i)
      begin
         s_d.v0 = s_q.v1;
         s_d.d0 = s_q.d1;
         s_d.v1 = 1'b0;
      end
      if (in_valid_i && !s_q.v1)
      begin
         if (s_d.v0)
         begin
            s_d.v1 = 1'b1;
            s_d.d1 = in_data_i;
         end
         else
         begin
            s_d.v0 = 1'b1;
            s_d.d0 = in_data_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign in_ready_o = !s_q.v1;
   assign out_valid_o = s_q.v0;
   assign out_data_o = s_q.d0;

   a_wbuf_holds_word:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
      else $error("buffered word changed while stalled");

endmodule // sgdc_wbuf

//--- design/sgdc_decoder.sv
`timescale 1ns/1ps
`include "sgdc_regs.svh"

module sgdc_decoder
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic cke_i,
   input wire sgdc_pkg::sgdc_pins_s pins_i,
   input wire logic [31:0] dq_i,
   output logic [31:0] dq_o,
   output logic [3:0] dq_oe_o,
   input wire logic [31:0] arr_rd_data_i,
   output sgdc_pkg::sgdc_rd_s arr_rd_o,
   output logic arr_act_o,
   output logic arr_act_bank_o,
   output logic [9:0] arr_act_row_o,
   output logic [1:0] arr_close_o,
   output logic arr_ref_o,
   output logic [10:0] arr_ref_row_o,
   output logic arr_wr_valid_o,
   input wire logic arr_wr_ready_i,
   output sgdc_pkg::sgdc_wr_s arr_wr_o,
   output logic [1:0] bank_open_o,
   output logic self_refresh_o,
   output logic power_down_o,
   output logic wr_overflow_o
);

   typedef struct packed {
      sgdc_pkg::sgdc_pwr_e pwr;
      logic cke_q;
      logic [9:0] mode;
      logic [1:0] mode_wait;
      logic [1:0][31:0] colour;
      logic [31:0] wmask;
      logic [1:0] open;
      logic [1:0] masked;
      logic [1:0][9:0] row;
      sgdc_pkg::sgdc_burst_e bk;
      logic b_bank;
      logic b_auto;
      logic [7:0] b_start;
      logic [7:0] b_cnt;
      logic [10:0] ref_row;
      logic [9:0] ref_tmr;
      logic act_v;
      logic act_bank;
      logic [9:0] act_row;
      logic [1:0] close;
      logic ref_v;
      sgdc_pkg::sgdc_rd_s rd;
      logic [31:0] p0;
      logic p0_v;
      logic [31:0] dq;
      logic dq_v;
      logic [3:0] dq_oe;
      logic [3:0] dqm1;
      logic w_v;
      sgdc_pkg::sgdc_wr_s w;
      logic ovf;
   } sgdc_state_s;

   sgdc_state_s s_q;
   sgdc_state_s s_d;
   sgdc_pkg::sgdc_cmd_e cmd;
   logic wbuf_ready;

   function automatic logic [31:0] sgdc_byte_exp(input logic [3:0] b);
      logic [31:0] r;
      r = '0;
      for (int i = 0; i < 4; i++)
         r[8*i +: 8] = {8{b[i]}};
      return r;
   endfunction

   function automatic logic [7:0] sgdc_len_mask(input logic [2:0] code);
      case (code)
         `SGDC_BL_1: return 8'h00;
         `SGDC_BL_2: return 8'h01;
         `SGDC_BL_4: return 8'h03;
         `SGDC_BL_8: return 8'h07;
         default: return 8'hFF;
      endcase
   endfunction

   // Command decode, qualified by select, previous enable, mode wait and the run power state
   always_comb
   begin
      cmd = sgdc_pkg::CMD_NONE;
      if (!pins_i.cs_n && s_q.cke_q && s_q.mode_wait == 2'h0 &&
          s_q.pwr == sgdc_pkg::PWR_RUN)
      begin
         case ({pins_i.ras_n, pins_i.cas_n, pins_i.we_n})
            3'h0: cmd = pins_i.special_function_pin ? sgdc_pkg::CMD_SMODE
                                                    : sgdc_pkg::CMD_MODE;
            3'h1: cmd = cke_i ? sgdc_pkg::CMD_REFRESH : sgdc_pkg::CMD_SELF_REFRESH_CMD;
            3'h2: cmd = sgdc_pkg::CMD_CLOSE;
            3'h3: cmd = pins_i.special_function_pin ? sgdc_pkg::CMD_OPEN_M
                                                    : sgdc_pkg::CMD_OPEN;
            3'h4: cmd = pins_i.special_function_pin ? sgdc_pkg::CMD_BLOCK
                                                    : sgdc_pkg::CMD_WRITE;
            3'h5: cmd = sgdc_pkg::CMD_READ;
            3'h6: cmd = sgdc_pkg::CMD_STOP;
            default: cmd = sgdc_pkg::CMD_NONE;
         endcase
      end
   end

   always_comb
   begin
      logic full;
      logic dual;
      logic [7:0] lmask;
      logic [7:0] col;
      logic [31:0] pbit;
      full = s_q.mode[`SGDC_MR_BL_MSB:`SGDC_MR_BL_LSB] == `SGDC_BL_FULL;
      dual = s_q.mode[`SGDC_MR_DUAL_BIT];
      lmask = 8'h00;
      col = 8'h00;
      pbit = 32'h0;
      s_d = s_q;
      s_d.act_v = 1'b0;
      s_d.close = 2'h0;
      s_d.ref_v = 1'b0;
      s_d.rd.valid = 1'b0;
      s_d.w_v = 1'b0;
      s_d.cke_q = cke_i;
      s_d.dqm1 = pins_i.dqm;
      if (s_q.w_v && !wbuf_ready)
         s_d.ovf = 1'b1;
      if (s_q.mode_wait != 2'h0)
         s_d.mode_wait = s_q.mode_wait - 2'h1;
      // Read data path with programmable latency
      s_d.p0 = arr_rd_data_i;
      s_d.p0_v = s_q.rd.valid;
      if (s_q.mode[`SGDC_MR_CL_MSB:`SGDC_MR_CL_LSB] == `SGDC_CL_3)
      begin
         s_d.dq = s_q.p0;
         s_d.dq_v = s_q.p0_v;
      end
      else
      begin
         s_d.dq = arr_rd_data_i;
         s_d.dq_v = s_q.rd.valid;
      end
      s_d.dq_oe = {4{s_d.dq_v}} & ~s_q.dqm1;
      case (s_q.pwr)
         sgdc_pkg::PWR_SELF_REFRESH_CMD:
         begin
            if (s_q.ref_tmr == 10'(`SGDC_REF_CYCLES - 1))
            begin
               s_d.ref_tmr = 10'h000;
               s_d.ref_v = 1'b1;
               s_d.ref_row = s_q.ref_row + 11'h001;
            end
            else
               s_d.ref_tmr = s_q.ref_tmr + 10'h001;
            if (cke_i)
               s_d.pwr = sgdc_pkg::PWR_RUN;
         end
         sgdc_pkg::PWR_DOWN:
         begin
            if (cke_i)
               s_d.pwr = sgdc_pkg::PWR_RUN;
         end
         default:
         begin
            case (cmd)
               sgdc_pkg::CMD_MODE:
               begin
                  s_d.mode = pins_i.addr;
                  s_d.mode_wait = `SGDC_MODE_WAIT;
               end
               sgdc_pkg::CMD_SMODE:
               begin
                  if (pins_i.addr[`SGDC_SM_MASK_BIT])
                     s_d.wmask = dq_i;
                  else if (pins_i.addr[`SGDC_SM_COLOUR_BIT])
                     s_d.colour[dual & pins_i.addr[`SGDC_SM_SEL_BIT]] = dq_i;
               end
               sgdc_pkg::CMD_OPEN, sgdc_pkg::CMD_OPEN_M:
               begin
                  s_d.open[pins_i.ba] = 1'b1;
                  s_d.row[pins_i.ba] = pins_i.addr;
                  s_d.masked[pins_i.ba] = cmd == sgdc_pkg::CMD_OPEN_M;
                  s_d.act_v = 1'b1;
                  s_d.act_bank = pins_i.ba;
                  s_d.act_row = pins_i.addr;
               end
               sgdc_pkg::CMD_READ, sgdc_pkg::CMD_WRITE:
               begin
                  s_d.bk = cmd == sgdc_pkg::CMD_READ ? sgdc_pkg::BK_READ
                                                      : sgdc_pkg::BK_WRITE;
                  s_d.b_bank = pins_i.ba;
                  s_d.b_start = pins_i.addr[`SGDC_COL_MSB:0];
                  s_d.b_cnt = 8'h00;
                  s_d.b_auto = pins_i.addr[`SGDC_AUTO_BIT] && !full;
               end
               sgdc_pkg::CMD_BLOCK:
               begin
                  s_d.bk = sgdc_pkg::BK_IDLE;
                  pbit = s_q.masked[pins_i.ba] ? s_q.wmask : 32'hFFFFFFFF;
                  s_d.w_v = 1'b1;
                  s_d.w.blk = 1'b1;
                  s_d.w.bank = pins_i.ba;
                  s_d.w.row = s_q.row[pins_i.ba];
                  s_d.w.col = {pins_i.addr[`SGDC_COL_MSB:`SGDC_BLK_LSB], 3'h0};
                  s_d.w.data = s_q.colour[dual & pins_i.addr[`SGDC_DUAL_SEL_BIT]];
                  s_d.w.bit_en = sgdc_byte_exp(~pins_i.dqm) & pbit;
                  s_d.w.col_en = dq_i;
                  if (pins_i.addr[`SGDC_AUTO_BIT] && !full)
                  begin
                     s_d.open[pins_i.ba] = 1'b0;
                     s_d.close[pins_i.ba] = 1'b1;
                  end
               end
               sgdc_pkg::CMD_STOP:
                  s_d.bk = sgdc_pkg::BK_IDLE;
               sgdc_pkg::CMD_CLOSE:
               begin
                  if (pins_i.addr[`SGDC_AUTO_BIT])
                     s_d.close = 2'h3;
                  else
                     s_d.close[pins_i.ba] = 1'b1;
                  s_d.open = s_q.open & ~s_d.close;
                  if (s_d.close[s_q.b_bank])
                     s_d.bk = sgdc_pkg::BK_IDLE;
               end
               sgdc_pkg::CMD_REFRESH:
               begin
                  s_d.ref_v = 1'b1;
                  s_d.ref_row = s_q.ref_row + 11'h001;
               end
               sgdc_pkg::CMD_SELF_REFRESH_CMD:
               begin
                  s_d.pwr = sgdc_pkg::PWR_SELF_REFRESH_CMD;
                  s_d.ref_tmr = 10'h000;
                  s_d.bk = sgdc_pkg::BK_IDLE;
               end
               default:
               begin
                  if (s_q.cke_q && !cke_i && s_q.bk == sgdc_pkg::BK_IDLE)
                     s_d.pwr = sgdc_pkg::PWR_DOWN;
               end
            endcase
         end
      endcase
      // One burst beat per clock
      if (s_d.bk != sgdc_pkg::BK_IDLE)
      begin
         lmask = sgdc_len_mask(s_q.mode[`SGDC_MR_BL_MSB:`SGDC_MR_BL_LSB]);
         if (s_d.bk == sgdc_pkg::BK_WRITE && s_q.mode[`SGDC_MR_SWR_BIT])
            lmask = 8'h00;
         if (s_q.mode[`SGDC_MR_BT_BIT] && !full)
            col = (s_d.b_start & ~lmask) | ((s_d.b_start ^ s_d.b_cnt) & lmask);
         else
            col = (s_d.b_start & ~lmask) | ((s_d.b_start + s_d.b_cnt) & lmask);
         if (s_d.bk == sgdc_pkg::BK_READ)
         begin
            s_d.rd.valid = 1'b1;
            s_d.rd.bank = s_d.b_bank;
            s_d.rd.row = s_d.row[s_d.b_bank];
            s_d.rd.col = col;
         end
         else
         begin
            pbit = s_d.masked[s_d.b_bank] ? s_d.wmask : 32'hFFFFFFFF;
            s_d.w_v = 1'b1;
            s_d.w.blk = 1'b0;
            s_d.w.bank = s_d.b_bank;
            s_d.w.row = s_d.row[s_d.b_bank];
            s_d.w.col = col;
            s_d.w.data = dq_i;
            s_d.w.bit_en = sgdc_byte_exp(~pins_i.dqm) & pbit;
            s_d.w.col_en = 32'h0;
         end
         if (s_d.b_cnt == lmask)
         begin
            s_d.bk = sgdc_pkg::BK_IDLE;
            if (s_d.b_auto)
            begin
               s_d.open[s_d.b_bank] = 1'b0;
               s_d.close[s_d.b_bank] = 1'b1;
            end
         end
         else
            s_d.b_cnt = s_d.b_cnt + 8'h01;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= '0;
         s_q.mode <= `SGDC_MR_RESET;
      end
      else
         s_q <= s_d;
   end

   sgdc_wbuf u_wbuf
   (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(s_q.w_v),
      .in_ready_o(wbuf_ready),
      .in_data_i(s_q.w),
      .out_valid_o(arr_wr_valid_o),
      .out_ready_i(arr_wr_ready_i),
      .out_data_o(arr_wr_o)
   );

   assign dq_o = s_q.dq;
   assign dq_oe_o = s_q.dq_oe;
   assign arr_rd_o = s_q.rd;
   assign arr_act_o = s_q.act_v;
   assign arr_act_bank_o = s_q.act_bank;
   assign arr_act_row_o = s_q.act_row;
   assign arr_close_o = s_q.close;
   assign arr_ref_o = s_q.ref_v;
   assign arr_ref_row_o = s_q.ref_row;
   assign bank_open_o = s_q.open;
   assign self_refresh_o = s_q.pwr == sgdc_pkg::PWR_SELF_REFRESH_CMD;
   assign power_down_o = s_q.pwr == sgdc_pkg::PWR_DOWN;
   assign wr_overflow_o = s_q.ovf;

   // Checks
   sequence sgdc_read_taken;
      cmd == sgdc_pkg::CMD_READ &&
      s_q.mode[`SGDC_MR_CL_MSB:`SGDC_MR_CL_LSB] == `SGDC_CL_2;
   endsequence

   sequence sgdc_mode_taken;
      cmd == sgdc_pkg::CMD_MODE;
   endsequence

   a_deselect_ignored:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      pins_i.cs_n && s_q.pwr != sgdc_pkg::PWR_SELF_REFRESH_CMD |=>
      !s_q.act_v && !s_q.ref_v && $stable(s_q.mode))
      else $error("command executed while deselected");

   a_nop_keeps_burst:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.bk == sgdc_pkg::BK_READ && cmd == sgdc_pkg::CMD_NONE |=> s_q.rd.valid)
      else $error("no-operation broke a running read");

   a_mode_wait_two:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      sgdc_mode_taken |=> (cmd == sgdc_pkg::CMD_NONE)[*2])
      else $error("command taken inside mode load wait");

   a_open_stores_row:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd == sgdc_pkg::CMD_OPEN |=> s_q.open[$past(pins_i.ba)] &&
      s_q.row[$past(pins_i.ba)] == $past(pins_i.addr))
      else $error("row open not recorded");

   a_read_latency_two:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      sgdc_read_taken |-> ##2 s_q.dq_v)
      else $error("first read word not at latency two");

   a_read_byte_mask:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.dq_v |-> ##0 ((s_q.dq_oe & $past(pins_i.dqm, 2)) == 4'h0))
      else $error("masked read lane driven");

   a_write_byte_mask:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.w_v |-> (s_q.w.bit_en & sgdc_byte_exp($past(pins_i.dqm))) == 32'h0)
      else $error("masked write byte enabled");

   a_self_refresh_cmd_holds_state:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      s_q.pwr == sgdc_pkg::PWR_SELF_REFRESH_CMD && !cke_i |=> self_refresh_o && !s_q.act_v)
      else $error("self refresh left or command run");

   a_refresh_row_step:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd == sgdc_pkg::CMD_REFRESH |=> s_q.ref_v &&
      s_q.ref_row == 11'($past(s_q.ref_row) + 11'h001))
      else $error("refresh row counter not advanced");

   a_close_all_banks:
   assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd == sgdc_pkg::CMD_CLOSE && pins_i.addr[`SGDC_AUTO_BIT] |=>
      s_q.open == 2'h0 && s_q.close == 2'h3)
      else $error("close all left a bank open");

endmodule // sgdc_decoder

//--- verification/sgdc_host.sv
`timescale 1ns/1ps
module sgdc_host
(
   input wire logic ref_clk_i,
   output logic cke_o,
   output sgdc_pkg::sgdc_pins_s pins_o,
   output logic [31:0] dq_o
);
   // One command per cycle, changed at the falling edge
   task automatic cmd(input logic [4:0] code, input logic ba, input logic [9:0] a,
                      input logic [3:0] dqm, input logic [31:0] d);
      @(negedge ref_clk_i);
      pins_o = {code, dqm, ba, a};
      dq_o = d;
   endtask
   // Idle cycles; released data lanes toggle
   task automatic nop(input int n);
      repeat (n)
      begin
         @(negedge ref_clk_i);
         pins_o = {5'h0E, 4'h0, 1'b0, 10'h000};
         dq_o = ~dq_o;
      end
   endtask
   task automatic set_cke(input logic v);
      cke_o = v;
   endtask
   initial
   begin
      cke_o = 1'b1;
      pins_o = {5'h1E, 4'hF, 1'b0, 10'h000};
      dq_o = 32'h0;
   end
endmodule // sgdc_host

//--- verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   localparam logic [4:0] C_MODE = 5'h00, C_SMODE = 5'h01, C_OPEN = 5'h06, C_OPENM = 5'h07,
      C_READ = 5'h0A, C_WRITE = 5'h08, C_BLOCK = 5'h09, C_STOP = 5'h0C, C_CLOSE = 5'h04,
      C_REF = 5'h02, C_DESEL = 5'h1A, C_NOP = 5'h0E;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic cke_i;
   sgdc_pkg::sgdc_pins_s pins_i;
   logic [31:0] dq_i, dq_o, arr_rd_data_i;
   logic [3:0] dq_oe_o;
   sgdc_pkg::sgdc_rd_s arr_rd_o;
   sgdc_pkg::sgdc_wr_s arr_wr_o;
   logic arr_act_o, arr_act_bank_o, arr_ref_o, arr_wr_valid_o, arr_wr_ready_i;
   logic [9:0] arr_act_row_o;
   logic [1:0] arr_close_o, bank_open_o;
   logic [10:0] arr_ref_row_o;
   logic self_refresh_o, power_down_o, wr_overflow_o;
   logic [8:0] rdq[$];
   logic [35:0] dqq[$];
   sgdc_pkg::sgdc_wr_s wrq[$];
   logic [10:0] actq[$], refq[$];
   logic [1:0] clsq[$];
   int cyc = 0, first_dq, t0, err_count = 0, checked = 0;

   function automatic logic [31:0] lanes(input logic [3:0] oe);
      return {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
   endfunction
   function automatic logic [31:0] rd_word(input logic b, input logic [7:0] c);
      return {16'hC0DE, 7'h00, b, c};
   endfunction

   assign arr_rd_data_i = rd_word(arr_rd_o.bank, arr_rd_o.col);
   always #10 ref_clk_i = ~ref_clk_i;

   sgdc_host i_sgdc_host (.ref_clk_i(ref_clk_i), .cke_o(cke_i), .pins_o(pins_i), .dq_o(dq_i));
   sgdc_decoder i_sgdc_decoder (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cke_i(cke_i),
      .pins_i(pins_i), .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
      .arr_rd_data_i(arr_rd_data_i), .arr_rd_o(arr_rd_o), .arr_act_o(arr_act_o),
      .arr_act_bank_o(arr_act_bank_o), .arr_act_row_o(arr_act_row_o),
      .arr_close_o(arr_close_o), .arr_ref_o(arr_ref_o), .arr_ref_row_o(arr_ref_row_o),
      .arr_wr_valid_o(arr_wr_valid_o), .arr_wr_ready_i(arr_wr_ready_i), .arr_wr_o(arr_wr_o),
      .bank_open_o(bank_open_o), .self_refresh_o(self_refresh_o),
      .power_down_o(power_down_o), .wr_overflow_o(wr_overflow_o));

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Array side and pin monitor, sampled at the rising edge
   always @(posedge ref_clk_i)
   begin
      if (arr_rd_o.valid === 1'b1) rdq.push_back({arr_rd_o.bank, arr_rd_o.col});
      if (dq_oe_o !== 4'h0) dqq.push_back({dq_oe_o, dq_o & lanes(dq_oe_o)});
      if (dq_oe_o !== 4'h0 && first_dq == 0) first_dq = cyc;
      if (arr_wr_valid_o === 1'b1 && arr_wr_ready_i === 1'b1) wrq.push_back(arr_wr_o);
      if (arr_act_o === 1'b1) actq.push_back({arr_act_bank_o, arr_act_row_o});
      if (arr_close_o !== 2'h0) clsq.push_back(arr_close_o);
      if (arr_ref_o === 1'b1) refq.push_back(arr_ref_row_o);
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         stop_test();
      end
   end

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      checked++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic op(input logic [4:0] code, input logic ba, input logic [9:0] a,
                     input logic [3:0] dqm = 4'h0, input logic [31:0] d = 32'h0);
      i_sgdc_host.cmd(code, ba, a, dqm, d);
   endtask
   task automatic idle(input int n);
      i_sgdc_host.nop(n);
   endtask
   task automatic clr();
      rdq.delete();
      dqq.delete();
      wrq.delete();
      actq.delete();
      clsq.delete();
      refq.delete();
      first_dq = 0;
   endtask
   // Four beats: columns packed one byte each, first word lanes oe0 (0 skips data)
   task automatic chk_rd(input logic [31:0] cols, input logic bk, input logic [3:0] oe0);
      logic [3:0] oe;
      chk(rdq.size(), 4, "beat count");
      for (int i = 0; i < 4; i++)
      begin
         oe = (i == 0) ? oe0 : 4'hF;
         chk(rdq[i], {bk, cols[8*i+:8]}, "beat column");
         if (oe0 != 4'h0)
            chk(dqq[i], {oe, rd_word(bk, cols[8*i+:8]) & lanes(oe)}, "read word");
      end
   endtask

   initial
   begin
      arr_wr_ready_i = 1'b1;
      repeat (10) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      chk({bank_open_o, dq_oe_o, arr_wr_valid_o, wr_overflow_o, self_refresh_o, power_down_o}, 0,
         "reset");
      idle(2);
      clr();
      op(C_MODE, 1'b0, 10'h0BA);
      op(C_OPEN, 1'b1, 10'h0AA);
      op(C_OPEN, 1'b1, 10'h0AA);
      op(C_OPEN, 1'b0, 10'h155);
      idle(2);
      chk(actq.size(), 1, "opens taken");
      chk(actq[0], {1'b0, 10'h155}, "open row");
      chk(bank_open_o, 2'h1, "open banks");
      clr();
      op(C_READ, 1'b0, 10'h015);
      t0 = cyc;
      op(C_NOP, 1'b0, 10'h000, 4'h2);
      idle(7);
      chk_rd(32'h1617_1415, 1'b0, 4'hD);
      chk(first_dq - t0, 3, "read latency");
      clr();
      op(C_DESEL, 1'b0, 10'h015);
      idle(6);
      chk(rdq.size() + dqq.size(), 0, "deselect");
      op(C_SMODE, 1'b0, 10'h020, 4'h0, 32'hFF00_F0F0);
      op(C_SMODE, 1'b0, 10'h040, 4'h0, 32'h1111_1111);
      op(C_SMODE, 1'b0, 10'h0C0, 4'h0, 32'h2222_2222);
      clr();
      op(C_OPENM, 1'b1, 10'h2AA);
      op(C_WRITE, 1'b1, 10'h008, 4'h1, 32'hDEAD_BEEF);
      op(C_STOP, 1'b0, 10'h000);
      op(C_BLOCK, 1'b1, 10'h029, 4'h8, 32'h0000_00FF);
      idle(4);
      chk(wrq.size(), 2, "write ops");
      chk({wrq[0].blk, wrq[0].bank, wrq[0].row, wrq[0].col}, {2'h1, 10'h2AA, 8'h08}, "wr");
      chk(wrq[0].bit_en, 32'hFF00_F000, "write bits");
      chk(wrq[0].data & wrq[0].bit_en, 32'hDE00_B000, "write data");
      chk({wrq[1].blk, wrq[1].bank, wrq[1].row, wrq[1].col}, {2'h3, 10'h2AA, 8'h28}, "bf");
      chk(wrq[1].data, 32'h2222_2222, "colour");
      chk(wrq[1].bit_en, 32'h0000_F0F0, "fill bits");
      chk(wrq[1].col_en, 32'h0000_00FF, "fill columns");
      clr();
      op(C_READ, 1'b0, 10'h103);
      idle(8);
      chk_rd(32'h0001_0203, 1'b0, 4'hF);
      chk(bank_open_o, 2'h2, "auto close");
      clr();
      op(C_CLOSE, 1'b1, 10'h000);
      idle(2);
      chk({clsq.size(), clsq[0], bank_open_o}, {32'h1, 2'h2, 2'h0}, "close one");
      op(C_OPEN, 1'b0, 10'h001);
      op(C_OPEN, 1'b1, 10'h002);
      clr();
      op(C_CLOSE, 1'b0, 10'h100);
      idle(2);
      chk({clsq.size(), clsq[0], bank_open_o}, {32'h1, 2'h3, 2'h0}, "close all");
      clr();
      op(C_REF, 1'b1, 10'h3FF);
      idle(1);
      op(C_REF, 1'b0, 10'h000);
      idle(2);
      chk({refq.size(), refq[0], refq[1]}, {32'h2, 11'h001, 11'h002}, "refresh rows");
      op(C_MODE, 1'b0, 10'h027);
      idle(2);
      op(C_OPEN, 1'b0, 10'h001);
      clr();
      arr_wr_ready_i = 1'b0;
      op(C_WRITE, 1'b0, 10'h000, 4'h0, 32'h1);
      idle(2);
      op(C_STOP, 1'b0, 10'h000);
      idle(1);
      chk({wrq.size(), wr_overflow_o}, {32'h0, 1'b1}, "overflow");
      arr_wr_ready_i = 1'b1;
      idle(3);
      chk({wrq.size(), wrq[0].col, wrq[1].col, arr_wr_valid_o}, {32'h2, 17'h0002}, "drain");
      clr();
      op(C_READ, 1'b0, 10'h1FE);
      t0 = cyc;
      idle(3);
      op(C_STOP, 1'b0, 10'h000);
      idle(6);
      chk_rd(32'h0100_FFFE, 1'b0, 4'h0);
      chk(first_dq - t0, 2, "latency two");
      chk(bank_open_o, 2'h1, "page keeps row");
      op(C_CLOSE, 1'b0, 10'h100);
      idle(2);
      i_sgdc_host.set_cke(1'b0);
      idle(2);
      chk(power_down_o, 1'b1, "power down entry");
      i_sgdc_host.set_cke(1'b1);
      idle(2);
      chk(power_down_o, 1'b0, "power down exit");
      clr();
      op(C_REF, 1'b0, 10'h000);
      i_sgdc_host.set_cke(1'b0);
      idle(2);
      chk(self_refresh_o, 1'b1, "self refresh");
      op(C_READ, 1'b0, 10'h000);
      op(C_OPEN, 1'b0, 10'h001);
      idle(3);
      chk(rdq.size() + actq.size(), 0, "inputs ignored");
      i_sgdc_host.set_cke(1'b1);
      for (int n = 0; n < 40 && self_refresh_o !== 1'b0; n++) idle(1);
      chk(self_refresh_o, 1'b0, "refresh exit");
      stop_test();
   end
endmodule // testbench
